// ==== hw/remote_decoder_consts.vh ====
// Constants for the MIDI remote-control decoder
`ifndef REMOTE_DECODER_CONSTS_VH
`define REMOTE_DECODER_CONSTS_VH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_CTRL          8'h00
`define OFS_STATUS        8'h04
`define OFS_POSITION      8'h08
`define OFS_LEVELS        8'h0c

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_ENABLE_BIT   0
`define CTRL_SURFACE_BIT  1
`define CTRL_FULLDISP_BIT 2
`define STAT_LOOP_BIT     7
`define CTRL_RESET        3'h2

// ------------------------------------------------------------
// MIDI message kinds and numbers
// ------------------------------------------------------------
`define KIND_NOTE_OFF     4'h8
`define KIND_NOTE_ON      4'h9
`define KIND_CC           4'hb
`define KIND_BEND         4'he
`define CC_VOLUME         7'h07
`define CC_GAIN           7'h09
`define CC_FADER_FIRST    7'h66
`define CC_FADER_LAST     7'h75
`define CC_TRIM_TOGGLE    7'h66
`define CC_SUBMIX_FIRST   7'h68
`define CH_SPECIAL        4'hc
`define GAIN_MAX          7'h3c
`define FADER_UNITY       7'h68

`define NOTE_DIM          7'h5d
`define NOTE_MONO         7'h2a
`define NOTE_TALK         7'h5e
`define NOTE_RECALL       7'h5f
`define NOTE_SPEAKER_B    7'h32
`define NOTE_CUE_FIRST    7'h3e
`define NOTE_CUE_LAST     7'h42
`define NOTE_SNAP_FIRST   7'h36
`define NOTE_SNAP_LAST    7'h3d
`define NOTE_TRIM         7'h2d
`define NOTE_MUTE         7'h2c
`define NOTE_SOLO         7'h2b
`define NOTE_ARM_FIRST    7'h00
`define NOTE_ARM_LAST     7'h07
`define NOTE_NAV_L1       7'h60
`define NOTE_NAV_R1       7'h61
`define NOTE_NAV_L8       7'h62
`define NOTE_NAV_R8       7'h63
`define NOTE_NAV_UP       7'h64
`define NOTE_NAV_DOWN     7'h65
`define CH_MASTER_FADER   4'h8

// ------------------------------------------------------------
// Probe note and timing
// ------------------------------------------------------------
`define PROBE_STATUS      8'h9f
`define PROBE_NOTE        8'h7f
`define PROBE_VELOCITY    8'h7f
`define PROBE_PERIOD_MS   500
`define CLK_FREQ_KHZ      250000
`define COL_LAST          6'h38
`define ROW_LAST          2'h2

`endif

// ==== hw/midi_msg_parser.v ====
// Assembles a MIDI byte stream into channel messages
module midi_msg_parser (
	input  wire       pclk,
	input  wire       presetn,
	input  wire [7:0] rx_data,
	input  wire       rx_valid,
	output reg        msg_valid,
	output reg  [7:0] msg_status,
	output reg  [6:0] msg_d1,
	output reg  [6:0] msg_d2
);

	reg       have_status_r;
	reg       have_d1_r;

	// ------------------------------------------------------------
	// Running status is kept; realtime bytes pass unseen
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msg_valid     <= 1'b0;
			msg_status    <= 8'h00;
			msg_d1        <= 7'h00;
			msg_d2        <= 7'h00;
			have_status_r <= 1'b0;
			have_d1_r     <= 1'b0;
		end else begin
			msg_valid <= 1'b0;
			if (rx_valid) begin
				if (rx_data[7]) begin
					if (rx_data < 8'hf0) begin
						msg_status    <= rx_data;
						have_status_r <= 1'b1;
						have_d1_r     <= 1'b0;
					end else if (rx_data < 8'hf8) begin
						have_status_r <= 1'b0;
						have_d1_r     <= 1'b0;
					end
				end else if (have_status_r) begin
					if (msg_status[7:5] == 3'h6) begin
						// Program change and channel pressure carry one byte
						msg_d1    <= rx_data[6:0];
						msg_d2    <= 7'h00;
						msg_valid <= 1'b1;
					end else if (!have_d1_r) begin
						msg_d1    <= rx_data[6:0];
						have_d1_r <= 1'b1;
					end else begin
						msg_d2    <= rx_data[6:0];
						have_d1_r <= 1'b0;
						msg_valid <= 1'b1;
					end
				end
			end
		end
	end

endmodule // midi_msg_parser

// ==== hw/midi_remote_decoder.v ====
// MIDI remote-control decoder with APB control registers
// Function
// - CC volume channel 1 sets main out
// - Monitoring buttons use notes on channel 1
// - Notes toggle dim, mono, talkback, speaker; recall note pulses
// - Notes select cue main or phones 1-4
// - Notes toggle trim, master mute, master solo
// - Surface protocol off ignores note commands
// - Fader CC is status, controller, value
// - Channel groups pick input, playback, output row
// - Controllers 66-75 pick fader, sixteen per channel
// - Channel 13 controller 66 toggles trim
// - Channel 13 controller pairs select submix
// - CC9 sets input gain up to 60
// - Probe note every half second; echo disables
// - Window shifts by one or eight
// - Arm buttons select output bus in place
// - Display feedback full or brief
// - Master fader drives main out
//
// Local design decisions: the placing of the registers and register access over APB.
`include "remote_decoder_consts.vh"

module midi_remote_decoder #(
	parameter [31:0] PROBE_CYCLES = `PROBE_PERIOD_MS * `CLK_FREQ_KHZ
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire [7:0]  rx_data,
	input  wire        rx_valid,
	output reg  [7:0]  tx_data,
	output reg         tx_valid,
	input  wire        tx_ready,
	output reg         fader_we,
	output reg  [1:0]  fader_row,
	output reg  [5:0]  fader_index,
	output reg  [6:0]  fader_value,
	output reg         main_vol_we,
	output reg  [6:0]  main_vol,
	output reg         gain_we,
	output reg  [3:0]  gain_channel,
	output reg  [6:0]  gain_value,
	output reg         snapshot_load,
	output reg  [2:0]  snapshot_index,
	output reg         recall_pulse,
	output reg         submix_we,
	output reg  [5:0]  submix,
	output reg         disp_req,
	output reg         disp_full,
	output reg  [1:0]  disp_row,
	output reg  [5:0]  disp_col,
	output reg  [7:0]  monitor_flags,
	output reg  [2:0]  cue_select
);

	localparam [1:0] TX_IDLE = 2'b01;
	localparam [1:0] TX_SEND = 2'b10;

	wire        msg_valid;
	wire [7:0]  msg_status;
	wire [6:0]  msg_d1;
	wire [6:0]  msg_d2;
	reg  [2:0]  ctrl_r;
	reg         loop_det_r;
	reg  [1:0]  row_r;
	reg  [5:0]  col_r;
	reg  [1:0]  row_nxt;
	reg  [5:0]  col_nxt;
	reg  [1:0]  tx_state_r;
	reg  [1:0]  tx_idx_r;
	reg  [31:0] probe_cnt_r;
	wire [3:0]  kind;
	wire [3:0]  chan;
	wire        apb_wr;
	wire        enabled;
	wire        surface_on;
	wire        note_press;
	wire        is_probe;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function [5:0] shift_col;
		input [5:0] col;
		input       left;
		input [5:0] step;
		begin
			if (left)
				shift_col = (col < step) ? 6'h00 : col - step;
			else
				shift_col = ({1'b0, col} + {1'b0, step} > {1'b0, `COL_LAST}) ?
				            `COL_LAST : col + step;
		end
	endfunction

	function in_range;
		input [6:0] v;
		input [6:0] lo;
		input [6:0] hi;
		begin
			in_range = (v >= lo) && (v <= hi);
		end
	endfunction

	midi_msg_parser u_parser (
		.pclk       (pclk),
		.presetn    (presetn),
		.rx_data    (rx_data),
		.rx_valid   (rx_valid),
		.msg_valid  (msg_valid),
		.msg_status (msg_status),
		.msg_d1     (msg_d1),
		.msg_d2     (msg_d2)
	);

	assign kind       = msg_status[7:4];
	assign chan       = msg_status[3:0];
	assign apb_wr     = psel && penable && pwrite;
	assign pready     = 1'b1;
	assign enabled    = ctrl_r[`CTRL_ENABLE_BIT];
	assign surface_on = ctrl_r[`CTRL_SURFACE_BIT];
	assign note_press = (kind == `KIND_NOTE_ON) && (msg_d2 != 7'h00);
	assign is_probe   = ({kind, chan} == `PROBE_STATUS) && ({1'b0, msg_d1} == `PROBE_NOTE);
	assign pslverr    = psel && penable && (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0);

	// ------------------------------------------------------------
	// APB read mux
	// ------------------------------------------------------------
	always @* begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			case (paddr)
				`OFS_CTRL:     prdata = {29'h0, ctrl_r};
				`OFS_STATUS:   prdata = {21'h0, cue_select, loop_det_r, monitor_flags[6:0]};
				`OFS_POSITION: prdata = {10'h0, submix, 6'h0, row_r, 2'h0, col_r};
				`OFS_LEVELS:   prdata = {13'h0, snapshot_index, 1'b0, gain_value, 1'b0, main_vol};
				default:       prdata = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Window position after a navigation key
	// ------------------------------------------------------------
	always @* begin
		col_nxt = col_r;
		row_nxt = row_r;
		case (msg_d1)
			`NOTE_NAV_L1:   col_nxt = shift_col(col_r, 1'b1, 6'h01);
			`NOTE_NAV_R1:   col_nxt = shift_col(col_r, 1'b0, 6'h01);
			`NOTE_NAV_L8:   col_nxt = shift_col(col_r, 1'b1, 6'h08);
			`NOTE_NAV_R8:   col_nxt = shift_col(col_r, 1'b0, 6'h08);
			`NOTE_NAV_UP:   row_nxt = (row_r == 2'h0) ? 2'h0 : row_r - 2'h1;
			`NOTE_NAV_DOWN: row_nxt = (row_r == `ROW_LAST) ? `ROW_LAST : row_r + 2'h1;
			default:        row_nxt = row_r;
		endcase
	end

	// ------------------------------------------------------------
	// Probe note transmitter
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_r  <= TX_IDLE;
			tx_idx_r    <= 2'h0;
			tx_valid    <= 1'b0;
			tx_data     <= 8'h00;
			probe_cnt_r <= 32'h0000_0000;
		end else begin
			probe_cnt_r <= (probe_cnt_r >= PROBE_CYCLES - 32'h1) ? 32'h0 : probe_cnt_r + 32'h1;
			case (tx_state_r)
				TX_IDLE: begin
					if (probe_cnt_r == PROBE_CYCLES - 32'h1) begin
						tx_state_r <= TX_SEND;
						tx_idx_r   <= 2'h0;
						tx_valid   <= 1'b1;
						tx_data    <= `PROBE_STATUS;
					end
				end
				TX_SEND: begin
					if (tx_ready) begin
						if (tx_idx_r == 2'h2) begin
							tx_state_r <= TX_IDLE;
							tx_valid   <= 1'b0;
						end else begin
							tx_idx_r <= tx_idx_r + 2'h1;
							tx_data  <= (tx_idx_r == 2'h0) ? `PROBE_NOTE : `PROBE_VELOCITY;
						end
					end
				end
				default: begin
					tx_state_r <= TX_IDLE;
					tx_valid   <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers and message decode
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r         <= `CTRL_RESET;
			loop_det_r     <= 1'b0;
			row_r          <= 2'h0;
			col_r          <= 6'h00;
			fader_we       <= 1'b0;
			fader_row      <= 2'h0;
			fader_index    <= 6'h00;
			fader_value    <= 7'h00;
			main_vol_we    <= 1'b0;
			main_vol       <= `FADER_UNITY;
			gain_we        <= 1'b0;
			gain_channel   <= 4'h0;
			gain_value     <= 7'h00;
			snapshot_load  <= 1'b0;
			snapshot_index <= 3'h0;
			recall_pulse   <= 1'b0;
			submix_we      <= 1'b0;
			submix         <= 6'h00;
			disp_req       <= 1'b0;
			disp_full      <= 1'b0;
			disp_row       <= 2'h0;
			disp_col       <= 6'h00;
			monitor_flags  <= 8'h00;
			cue_select     <= 3'h0;
		end else begin
			fader_we      <= 1'b0;
			main_vol_we   <= 1'b0;
			gain_we       <= 1'b0;
			snapshot_load <= 1'b0;
			recall_pulse  <= 1'b0;
			submix_we     <= 1'b0;
			disp_req      <= 1'b0;
			if (apb_wr && paddr == `OFS_CTRL)
				ctrl_r <= pwdata[2:0];
			if (apb_wr && paddr == `OFS_STATUS && pwdata[`STAT_LOOP_BIT])
				loop_det_r <= 1'b0;
			if (msg_valid && is_probe) begin
				loop_det_r                <= 1'b1;
				ctrl_r[`CTRL_ENABLE_BIT] <= 1'b0;
			end else if (msg_valid && enabled) begin
				if (note_press && chan == 4'h0 && surface_on) begin
					if (msg_d1 == `NOTE_DIM)
						monitor_flags[0] <= ~monitor_flags[0];
					if (msg_d1 == `NOTE_MONO)
						monitor_flags[1] <= ~monitor_flags[1];
					if (msg_d1 == `NOTE_TALK)
						monitor_flags[2] <= ~monitor_flags[2];
					if (msg_d1 == `NOTE_SPEAKER_B)
						monitor_flags[3] <= ~monitor_flags[3];
					if (msg_d1 == `NOTE_RECALL)
						recall_pulse <= 1'b1;
					if (msg_d1 == `NOTE_TRIM)
						monitor_flags[4] <= ~monitor_flags[4];
					if (msg_d1 == `NOTE_MUTE)
						monitor_flags[5] <= ~monitor_flags[5];
					if (msg_d1 == `NOTE_SOLO)
						monitor_flags[6] <= ~monitor_flags[6];
					if (in_range(msg_d1, `NOTE_CUE_FIRST, `NOTE_CUE_LAST))
						cue_select <= msg_d1[2:0] - 3'h5;
					if (in_range(msg_d1, `NOTE_SNAP_FIRST, `NOTE_SNAP_LAST)) begin
						snapshot_load  <= 1'b1;
						snapshot_index <= msg_d1[2:0] - 3'h6;
					end
					if (in_range(msg_d1, `NOTE_ARM_FIRST, `NOTE_ARM_LAST)) begin
						submix_we <= 1'b1;
						submix    <= col_r + {3'h0, msg_d1[2:0]};
					end
					if (in_range(msg_d1, `NOTE_NAV_L1, `NOTE_NAV_DOWN)) begin
						disp_req  <= 1'b1;
						disp_full <= ctrl_r[`CTRL_FULLDISP_BIT];
						disp_row  <= row_nxt;
						disp_col  <= col_nxt;
						col_r     <= col_nxt;
						row_r     <= row_nxt;
					end
				end
				if (kind == `KIND_BEND && surface_on) begin
					if (chan == `CH_MASTER_FADER) begin
						main_vol_we <= 1'b1;
						main_vol    <= msg_d2;
					end else if (chan < 4'h8) begin
						fader_we    <= 1'b1;
						fader_row   <= row_r;
						fader_index <= col_r + {3'h0, chan[2:0]};
						fader_value <= msg_d2;
					end
				end
				if (kind == `KIND_CC) begin
					if (chan == 4'h0 && msg_d1 == `CC_VOLUME) begin
						main_vol_we <= 1'b1;
						main_vol    <= msg_d2;
					end
					if (msg_d1 == `CC_GAIN && msg_d2 <= `GAIN_MAX) begin
						gain_we      <= 1'b1;
						gain_channel <= chan;
						gain_value   <= msg_d2;
					end
					if (chan < `CH_SPECIAL &&
					    in_range(msg_d1, `CC_FADER_FIRST, `CC_FADER_LAST)) begin
						fader_we    <= 1'b1;
						fader_row   <= chan[3:2];
						fader_index <= {chan[1:0], msg_d1[3:0] - 4'h6};
						fader_value <= msg_d2;
					end
					if (chan == `CH_SPECIAL && msg_d1 == `CC_TRIM_TOGGLE)
						monitor_flags[4] <= ~monitor_flags[4];
					if (chan == `CH_SPECIAL &&
					    in_range(msg_d1, `CC_SUBMIX_FIRST, `CC_FADER_LAST)) begin
						submix_we        <= 1'b1;
						submix           <= {1'b0, msg_d1[4:0] - 5'h08} & 6'h1e;
						monitor_flags[4] <= 1'b0;
					end
				end
			end
		end
	end

endmodule // midi_remote_decoder

// ==== testbench/midi_surface_model.sv ====
// Behavioural control surface: sends MIDI bytes, takes probe bytes
module midi_surface_model (
	output logic       [7:0] rx_data,
	output logic             rx_valid,
	output logic             tx_ready,
	input  wire logic        pclk,
	input  wire logic  [7:0] tx_data,
	input  wire logic        tx_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       slow;
	logic [7:0] txq[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
		slow = 1'b1;
	end
	// Idle data line shows the inverse of the last byte
	task send(input logic [7:0] b);
		@(posedge pclk);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask
	task msg(input logic [3:0] kind, input int ch, input logic [7:0] d1, input logic [7:0] d2);
		send({kind, 4'(ch - 1)});
		send(d1);
		send(d2);
	endtask
	// Slow mode accepts a probe byte every other cycle
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			txq.push_back(tx_data);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
endmodule // midi_surface_model

// ==== testbench/midi_remote_decoder_sva.sv ====
// Port assertions for the MIDI remote-control decoder
module midi_remote_decoder_sva (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [7:0] rx_data,
	input wire logic       rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic       fader_we,
	input wire logic [1:0] fader_row,
	input wire logic [6:0] fader_value,
	input wire logic       main_vol_we,
	input wire logic [6:0] main_vol,
	input wire logic       gain_we,
	input wire logic [6:0] gain_value,
	input wire logic       submix_we,
	input wire logic       disp_req,
	input wire logic [1:0] disp_row,
	input wire logic [5:0] disp_col,
	input wire logic [7:0] monitor_flags,
	input wire logic [2:0] cue_select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_FADER_CAUSE: assert property (fader_we |->
		$past(rx_valid, 2) && {1'b0, fader_value} == $past(rx_data, 2)) else $error("fader value");
	AST_FADER_ROW: assert property (fader_we |-> fader_row != 2'h3) else $error("fader row");
	AST_FADER_ONCE: assert property (fader_we |=> !fader_we) else $error("fader twice");
	AST_VOL_CAUSE: assert property (main_vol_we |->
		$past(rx_valid, 2) && {1'b0, main_vol} == $past(rx_data, 2)) else $error("main volume");
	AST_GAIN_LIMIT: assert property (gain_we |->
		gain_value <= 7'h3c && {1'b0, gain_value} == $past(rx_data, 2)) else $error("gain value");
	AST_SUBMIX_CAUSE: assert property (submix_we |-> $past(rx_valid, 2)) else $error("submix");
	AST_WINDOW_RANGE: assert property (disp_req |->
		disp_col <= 6'h38 && disp_row <= 2'h2) else $error("window position");
	AST_CUE_RANGE: assert property (cue_select <= 3'h5 && !monitor_flags[7]) else $error("cue");
	AST_PROBE_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data)) else $error("probe byte dropped");
	AST_PROBE_START: assert property ($rose(tx_valid) |-> tx_data == 8'h9f)
		else $error("probe status");
endmodule // midi_remote_decoder_sva

bind midi_remote_decoder midi_remote_decoder_sva midi_remote_decoder_sva_inst (
	.pclk(pclk), .presetn(presetn), .rx_data(rx_data), .rx_valid(rx_valid),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .fader_we(fader_we),
	.fader_row(fader_row), .fader_value(fader_value), .main_vol_we(main_vol_we),
	.main_vol(main_vol), .gain_we(gain_we), .gain_value(gain_value), .submix_we(submix_we),
	.disp_req(disp_req), .disp_row(disp_row), .disp_col(disp_col),
	.monitor_flags(monitor_flags), .cue_select(cue_select));

// ==== testbench/tb.sv ====
// Self-checking testbench for the MIDI remote-control decoder
`include "remote_decoder_consts.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [3:0] kind; int ch; logic [7:0] d1; logic [7:0] d2; int k;
		logic [31:0] e;} row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr, rx_data, tx_data;
	logic [31:0] pwdata, prdata, rd, lastv;
	logic        rx_valid, tx_valid, tx_ready, fader_we, main_vol_we, gain_we, snapshot_load;
	logic        recall_pulse, submix_we, disp_req, disp_full;
	logic [1:0]  fader_row, disp_row;
	logic [5:0]  fader_index, submix, disp_col;
	logic [6:0]  fader_value, main_vol, gain_value;
	logic [3:0]  gain_channel;
	logic [2:0]  snapshot_index, cue_select;
	logic [7:0]  monitor_flags;
	int          mismatches, checks, pulses, lastk;
	// Kinds: 0 fader 1 volume 2 gain 3 snapshot 4 recall 5 submix 6 cue 7 flags 8 none 9 display
	row_t rows[] = '{
		'{4'hb, 1, 8'h66, 8'h68, 0, 32'h68}, '{4'hb, 2, 8'h66, 8'h00, 0, 32'h800},
		'{4'hb, 5, 8'h66, 8'h7f, 0, 32'h207f}, '{4'hb, 9, 8'h75, 8'h68, 0, 32'h47e8},
		'{4'hb, 12, 8'h75, 8'h01, 0, 32'h5f81}, '{4'hb, 1, 8'h07, 8'h55, 1, 32'h55},
		'{4'hb, 4, 8'h09, 8'h3c, 2, 32'h1bc}, '{4'hb, 4, 8'h09, 8'h3d, 8, 0},
		'{4'h9, 1, 8'h36, 8'h40, 3, 0}, '{4'h9, 1, 8'h3d, 8'h40, 3, 7},
		'{4'h9, 1, 8'h5f, 8'h40, 4, 0}, '{4'h9, 1, 8'h3e, 8'h40, 6, 1},
		'{4'h9, 1, 8'h42, 8'h40, 6, 5}, '{4'h9, 1, 8'h5d, 8'h40, 7, 8'h01},
		'{4'h9, 1, 8'h2a, 8'h40, 7, 8'h03}, '{4'h9, 1, 8'h5e, 8'h40, 7, 8'h07},
		'{4'h9, 1, 8'h32, 8'h40, 7, 8'h0f}, '{4'h9, 1, 8'h2d, 8'h40, 7, 8'h1f},
		'{4'h9, 1, 8'h2c, 8'h40, 7, 8'h3f}, '{4'h9, 1, 8'h2b, 8'h40, 7, 8'h7f},
		'{4'hb, 13, 8'h66, 8'h00, 7, 8'h6f}, '{4'hb, 13, 8'h66, 8'h7f, 7, 8'h7f},
		'{4'hb, 13, 8'h68, 8'h00, 5, 0}, '{4'h9, 2, 8'h5d, 8'h40, 7, 8'h6f},
		'{4'h8, 1, 8'h5d, 8'h40, 7, 8'h6f}, '{4'h9, 1, 8'h5d, 8'h00, 7, 8'h6f},
		'{4'hb, 13, 8'h6b, 8'h00, 5, 2}, '{4'hb, 13, 8'h75, 8'h00, 5, 8'h0c},
		'{4'h9, 1, 8'h61, 8'h40, 9, 1}, '{4'h9, 1, 8'h63, 8'h40, 9, 9},
		'{4'h9, 1, 8'h65, 8'h40, 9, 8'h49}, '{4'h9, 1, 8'h62, 8'h40, 9, 8'h41},
		'{4'h9, 1, 8'h60, 8'h40, 9, 8'h40}, '{4'h9, 1, 8'h02, 8'h40, 5, 2},
		'{4'he, 1, 8'h00, 8'h68, 0, 32'h2068}, '{4'he, 9, 8'h00, 8'h40, 1, 8'h40},
		'{4'hb, 1, 8'h20, 8'h11, 8, 0}, '{4'hb, 14, 8'h66, 8'h10, 8, 0}};

	midi_remote_decoder #(.PROBE_CYCLES(32'd200)) midi_remote_decoder_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .fader_we(fader_we), .fader_row(fader_row),
		.fader_index(fader_index), .fader_value(fader_value), .main_vol_we(main_vol_we),
		.main_vol(main_vol), .gain_we(gain_we), .gain_channel(gain_channel),
		.gain_value(gain_value), .snapshot_load(snapshot_load),
		.snapshot_index(snapshot_index), .recall_pulse(recall_pulse), .submix_we(submix_we),
		.submix(submix), .disp_req(disp_req), .disp_full(disp_full), .disp_row(disp_row),
		.disp_col(disp_col), .monitor_flags(monitor_flags), .cue_select(cue_select));
	midi_surface_model surface_inst (.pclk(pclk), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ------------------------------------------------------------
	// Pulse monitor
	// ------------------------------------------------------------
	task note(input int k, input logic [31:0] v);
		pulses++;
		lastk = k;
		lastv = v;
	endtask
	always @(posedge pclk) begin
		if (fader_we) note(0, {fader_row, fader_index, fader_value});
		if (main_vol_we) note(1, main_vol);
		if (gain_we) note(2, {gain_channel, gain_value});
		if (snapshot_load) note(3, snapshot_index);
		if (recall_pulse) note(4, 0);
		if (submix_we) note(5, submix);
		if (disp_req) note(9, {disp_full, disp_row, disp_col});
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task run_row(input row_t r);
		int p;
		p = pulses;
		surface_inst.msg(r.kind, r.ch, r.d1, r.d2);
		repeat (4) @(posedge pclk);
		#1;
		case (r.k)
			6: check("cue", cue_select, r.e);
			7: check("flags", monitor_flags, r.e);
			8: check("pulses", pulses, p);
			default: begin
				check("pulses", pulses, p + 1);
				check("kind", lastk, r.k);
				check("value", lastv, r.e);
			end
		endcase
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `OFS_CTRL, 0);
		check("ctrl reset", rd, 32'h2);
		check("ready", pready, 1'b1);
		check("volume reset", main_vol, 32'h68);
		apb(0, 8'h40, 0);
		check("unmapped error", er, 1);
		check("unmapped data", rd, 0);
		run_row('{4'hb, 1, 8'h66, 8'h11, 8, 0});
		apb(1, `OFS_CTRL, 32'h3);
		foreach (rows[i]) run_row(rows[i]);
		apb(1, `OFS_CTRL, 32'h1);
		run_row('{4'h9, 1, 8'h5d, 8'h40, 7, 8'h6f});
		run_row('{4'hb, 1, 8'h66, 8'h22, 0, 32'h22});
		apb(1, `OFS_CTRL, 32'h7);
		run_row('{4'h9, 1, 8'h61, 8'h40, 9, 32'h141});
		apb(0, `OFS_POSITION, 0);
		check("position", rd, 32'h0002_0101);
		apb(0, `OFS_LEVELS, 0);
		check("levels", rd, 32'h0007_3c40);
		surface_inst.slow <= 1'b0;
		while (surface_inst.txq.size() < 9) @(posedge pclk);
		foreach (surface_inst.txq[i])
			check("probe byte", surface_inst.txq[i], (i % 3 == 0) ? 8'h9f : 8'h7f);
		surface_inst.msg(4'h9, 16, 8'h7f, 8'h40);
		apb(0, `OFS_STATUS, 0);
		check("loop flag", rd[7], 1);
		check("status", rd, 32'h0000_05ef);
		apb(0, `OFS_CTRL, 0);
		check("enable after loop", rd[0], 0);
		run_row('{4'hb, 1, 8'h66, 8'h33, 8, 0});
		apb(1, `OFS_STATUS, 32'h80);
		apb(0, `OFS_STATUS, 0);
		check("loop clear", rd[7], 0);
		apb(1, `OFS_CTRL, 32'h3);
		run_row('{4'hb, 1, 8'h66, 8'h33, 0, 32'h33});
		summarize();
	end
endmodule // tb
